// ### hw/swct_top.sv
// Suspend entry, wake-up clock sequencing and wake-up timer control.
// Assumes a 20 MHz clock, a plain register port from the processor,
// and asynchronous wake and oscillator-stable levels from outside.
//
// Local design decisions: the address map and the plain strobed port.
`include "swct_cfg.svh"

// Behaviour
// RL1 - Select clear at suspend: wake on internal clock
// RL2 - Writing suspend bit enters suspend
// RL3 - Internal clock restarts within 2 us
// RL4 - Internal wake waits 8 us before execution
// RL5 - Late external select halts, stabilises, then delays
// RL6 - Firmware keeps external select set at suspend
// RL7 - External wake starts oscillator, waits stable
// RL8 - Then 128 us or 4 ms delay
// RL9 - Wake timer runs only while enabled
// RL10 - Timer ignores suspend and global enable
// RL11 - Timer interrupts every period while enabled
// RL12 - Disabling timer resets its count
// RL13 - Adjust field bits 6:4, cleared by reset
// RL14 - Period is two to adjust times base
// RL15 - Firmware may calibrate against millisecond tick
// RL16 - Run bit must be set to resume
// RL17 - Timer expiry sets pending wake flag
module swct_top #(
   parameter int LONG_DLY_CYC = `SWCT_EXT_LONG_CYC,
   parameter int WAKE_BASE_CYC = `SWCT_WAKE_BASE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic wake_event_i,
   input wire logic ext_stable_i,
   output logic cpu_run_o,
   output logic suspend_o,
   output logic int_clk_en_o,
   output logic ext_osc_en_o,
   output logic ext_clk_sel_o,
   output logic irq_o
);

   localparam int CW = swct_pkg::SWCT_CNT_W;
   localparam logic [CW-1:0] ONE_C = 17'h00001;
   localparam logic [CW-1:0] RESTART_C = CW'(`SWCT_RESTART_CYC);
   localparam logic [CW-1:0] SYNC_C = CW'(`SWCT_SYNC_CYC);
   localparam logic [CW-1:0] INT_TMO_C = CW'(`SWCT_INT_TMO_CYC);
   localparam logic [CW-1:0] SHORT_C = CW'(`SWCT_EXT_SHORT_CYC);
   localparam logic [CW-1:0] LONG_C = CW'(LONG_DLY_CYC);

   swct_pkg::swct_regs_t s_q;
   swct_pkg::swct_regs_t s_d;
   logic tmr_expire;
   logic wake_req;
   logic [1:0] ev;

   // ----------------------------------------------------------------------
   // Wake-up timer
   // ----------------------------------------------------------------------
   // Gated by its own enable alone, not by suspend or global enable
   swct_wake_timer #(
      .BASE_CYC(WAKE_BASE_CYC)
   ) swct_wake_timer_i (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(s_q.mask[`SWCT_EV_WAKE_BIT]), // RL10
      .adj_i(s_q.adj),
      .expire_o(tmr_expire)
   );

   // ----------------------------------------------------------------------
   // Wake conditions and events
   // ----------------------------------------------------------------------
   // Pin wake or an enabled pending timer wake, only with run set
   assign wake_req = (s_q.wake_s
      | (s_q.stat[`SWCT_EV_WAKE_BIT] & s_q.mask[`SWCT_EV_WAKE_BIT])) & s_q.run; // RL16

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      ev = 2'h0;
      s_d.rdata = 8'h00;
      // Two-stage synchronisers
      s_d.wake_m = wake_event_i;
      s_d.wake_s = s_q.wake_m;
      s_d.stab_m = ext_stable_i;
      s_d.stab_s = s_q.stab_m;
      ev[`SWCT_EV_WAKE_BIT] = tmr_expire; // RL17
      if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - ONE_C;
      end

      // Register writes
      if (wr_i) begin
         case (addr_i)
            `SWCT_ADDR_CLKCFG: begin
               s_d.ext_sel = wdata_i[`SWCT_CFG_EXT_BIT];
               s_d.adj = wdata_i[`SWCT_CFG_ADJ_LSB +: 3]; // RL13
               s_d.dly_long = wdata_i[`SWCT_CFG_LONG_BIT];
               // Switch to external clock while running internal
               if (s_q.state == swct_pkg::SWCT_RUN && !s_q.ext_active
                  && !s_q.ext_sel && wdata_i[`SWCT_CFG_EXT_BIT]) begin
                  s_d.state = swct_pkg::SWCT_EXT_STAB; // RL5
               end
            end
            `SWCT_ADDR_PSC: begin
               s_d.run = wdata_i[`SWCT_PSC_RUN_BIT];
               if (s_q.state == swct_pkg::SWCT_RUN && wdata_i[`SWCT_PSC_SUSP_BIT]) begin
                  s_d.state = swct_pkg::SWCT_SUSP; // RL2
                  s_d.wake_ext = s_q.ext_sel;
               end
            end
            `SWCT_ADDR_MASK: begin
               s_d.mask = wdata_i[1:0];
            end
            default: begin
               s_d.mask = s_q.mask;
            end
         endcase
      end

      // Register reads, data in the next cycle
      if (rd_i) begin
         case (addr_i)
            `SWCT_ADDR_CLKCFG: begin
               s_d.rdata = {s_q.dly_long, s_q.adj, 3'h0, s_q.ext_sel};
            end
            `SWCT_ADDR_PSC: begin
               s_d.rdata = {4'h0, s_q.state == swct_pkg::SWCT_SUSP, 2'h0, s_q.run};
            end
            `SWCT_ADDR_MASK: begin
               s_d.rdata = {6'h00, s_q.mask};
            end
            `SWCT_ADDR_STAT: begin
               s_d.rdata = {6'h00, s_q.stat};
               s_d.stat = 2'h0;
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end

      // Wake sequencer
      case (s_q.state)
         swct_pkg::SWCT_RUN: begin
            s_d.cnt = '0;
         end
         swct_pkg::SWCT_SUSP: begin
            if (wake_req) begin
               if (s_q.wake_ext) begin
                  s_d.state = swct_pkg::SWCT_EXT_STAB; // RL7
               end else begin
                  s_d.state = swct_pkg::SWCT_INT_START; // RL1
                  s_d.ext_active = 1'b0;
                  s_d.cnt = RESTART_C - SYNC_C - ONE_C; // Pin sync latency inside 2 us
               end
            end
         end
         swct_pkg::SWCT_INT_START: begin
            if (s_q.cnt == '0) begin
               s_d.state = swct_pkg::SWCT_INT_TMO; // RL3
               s_d.cnt = INT_TMO_C - ONE_C;
            end
         end
         swct_pkg::SWCT_INT_TMO: begin
            if (s_q.cnt == '0) begin
               s_d.state = swct_pkg::SWCT_RUN; // RL4
               ev[`SWCT_EV_RESUME_BIT] = 1'b1;
            end
         end
         swct_pkg::SWCT_EXT_STAB: begin
            if (s_q.stab_s) begin
               s_d.state = swct_pkg::SWCT_EXT_DLY;
               s_d.cnt = (s_q.dly_long ? LONG_C : SHORT_C) - ONE_C; // RL8
            end
         end
         swct_pkg::SWCT_EXT_DLY: begin
            if (s_q.cnt == '0) begin
               s_d.state = swct_pkg::SWCT_RUN; // RL8
               s_d.ext_active = 1'b1;
               ev[`SWCT_EV_RESUME_BIT] = 1'b1;
            end
         end
         default: begin
            s_d.state = swct_pkg::SWCT_RUN;
         end
      endcase

      // Clock enables follow the next state
      s_d.int_clk = (s_d.state == swct_pkg::SWCT_INT_TMO)
         || (s_d.state == swct_pkg::SWCT_RUN && !s_d.ext_active);
      s_d.ext_osc = (s_d.state == swct_pkg::SWCT_EXT_STAB) // RL7
         || (s_d.state == swct_pkg::SWCT_EXT_DLY)
         || (s_d.state == swct_pkg::SWCT_RUN && s_d.ext_active);

      // Sticky events, a set beats a read clear
      s_d.stat = s_d.stat | ev;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0; // RL13
         s_q.state <= swct_pkg::SWCT_RUN;
         s_q.run <= `SWCT_RUN_RST;
         s_q.int_clk <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign rdata_o = s_q.rdata;
   assign cpu_run_o = (s_q.state == swct_pkg::SWCT_RUN);
   assign suspend_o = (s_q.state == swct_pkg::SWCT_SUSP);
   assign int_clk_en_o = s_q.int_clk;
   assign ext_osc_en_o = s_q.ext_osc;
   assign ext_clk_sel_o = s_q.ext_active;
   assign irq_o = |(s_q.stat & s_q.mask);

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic [CW-1:0] h_dly;

   // Cycles spent in the external delay state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         h_dly <= '0;
      end else if (s_q.state == swct_pkg::SWCT_EXT_DLY) begin
         h_dly <= h_dly + ONE_C;
      end else begin
         h_dly <= '0;
      end
   end

   a_internal_wake: assert property ( // RL1
      @(posedge clk_i) disable iff (rst_i)
      suspend_o && wake_req && !s_q.wake_ext
      |=> s_q.state == swct_pkg::SWCT_INT_START && !ext_clk_sel_o)
      else $error("internal wake path not taken");

   a_suspend_entry: assert property ( // RL2
      @(posedge clk_i) disable iff (rst_i)
      wr_i && addr_i == `SWCT_ADDR_PSC && wdata_i[`SWCT_PSC_SUSP_BIT] && cpu_run_o
      |=> suspend_o && !cpu_run_o)
      else $error("suspend not entered");

   a_restart_bound: assert property ( // RL3
      @(posedge clk_i) disable iff (rst_i)
      $rose(s_q.state == swct_pkg::SWCT_INT_START) |-> ##[1:40] int_clk_en_o)
      else $error("internal clock restart too late");

   a_internal_tmo: assert property ( // RL4
      @(posedge clk_i) disable iff (rst_i)
      $rose(s_q.state == swct_pkg::SWCT_INT_TMO)
      |-> ##159 !cpu_run_o ##1 cpu_run_o)
      else $error("internal wake time-out wrong");

   a_switch_halt: assert property ( // RL5
      @(posedge clk_i) disable iff (rst_i)
      wr_i && addr_i == `SWCT_ADDR_CLKCFG && wdata_i[`SWCT_CFG_EXT_BIT]
      && cpu_run_o && !ext_clk_sel_o && !s_q.ext_sel
      |=> !int_clk_en_o && !cpu_run_o && ext_osc_en_o)
      else $error("clock switch did not halt internal clock");

   a_stab_wait: assert property ( // RL7
      @(posedge clk_i) disable iff (rst_i)
      s_q.state == swct_pkg::SWCT_EXT_STAB && !s_q.stab_s
      |=> s_q.state == swct_pkg::SWCT_EXT_STAB && ext_osc_en_o)
      else $error("left stabilisation before stable");

   a_ext_delay: assert property ( // RL8
      @(posedge clk_i) disable iff (rst_i)
      $past(s_q.state) == swct_pkg::SWCT_EXT_DLY && cpu_run_o
      |-> h_dly == (s_q.dly_long ? LONG_C : SHORT_C))
      else $error("external resume delay wrong");

   a_expiry_pending: assert property ( // RL17
      @(posedge clk_i) disable iff (rst_i)
      tmr_expire |=> s_q.stat[`SWCT_EV_WAKE_BIT])
      else $error("timer expiry not recorded");

   a_internal_kept: assert property ( // RL1
      @(posedge clk_i) disable iff (rst_i)
      cpu_run_o && !ext_clk_sel_o |-> int_clk_en_o && !ext_osc_en_o)
      else $error("internal clock lost while running");

   a_external_kept: assert property ( // RL8
      @(posedge clk_i) disable iff (rst_i)
      cpu_run_o && ext_clk_sel_o |-> ext_osc_en_o && !int_clk_en_o)
      else $error("external clock lost while running");

   a_run_gate: assert property ( // RL16
      @(posedge clk_i) disable iff (rst_i)
      suspend_o && !s_q.run |=> suspend_o)
      else $error("resumed with run bit clear");

endmodule : swct_top

// ### hw/swct_cfg.svh
// Constants of the suspend, wake and clock timer block.
// Assumes a 20 MHz system clock; included by its bare name.
`ifndef SWCT_CFG_SVH
`define SWCT_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SWCT_CLK_NS 50
`define SWCT_RESTART_NS 2000
`define SWCT_RESTART_CYC (`SWCT_RESTART_NS / `SWCT_CLK_NS)
`define SWCT_SYNC_CYC 3
`define SWCT_INT_TMO_NS 8000
`define SWCT_INT_TMO_CYC ((`SWCT_INT_TMO_NS + `SWCT_CLK_NS - 1) / `SWCT_CLK_NS)
`define SWCT_EXT_SHORT_NS 128000
`define SWCT_EXT_SHORT_CYC ((`SWCT_EXT_SHORT_NS + `SWCT_CLK_NS - 1) / `SWCT_CLK_NS)
`define SWCT_EXT_LONG_NS 4000000
`define SWCT_EXT_LONG_CYC ((`SWCT_EXT_LONG_NS + `SWCT_CLK_NS - 1) / `SWCT_CLK_NS)
`define SWCT_WAKE_BASE_CYC 1000

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SWCT_ADDR_CLKCFG 8'h00
`define SWCT_ADDR_PSC 8'h01
`define SWCT_ADDR_MASK 8'h02
`define SWCT_ADDR_STAT 8'h03

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SWCT_CFG_EXT_BIT 0
`define SWCT_CFG_ADJ_LSB 4
`define SWCT_CFG_LONG_BIT 7
`define SWCT_PSC_RUN_BIT 0
`define SWCT_PSC_SUSP_BIT 3
`define SWCT_EV_WAKE_BIT 0
`define SWCT_EV_RESUME_BIT 1
`define SWCT_RUN_RST 1'b1

`endif

// ### hw/swct_pkg.sv
// Types of the suspend, wake and clock timer block.
// Assumes nothing beyond a SystemVerilog compiler.
package swct_pkg;

   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int SWCT_CNT_W = 17;
   localparam int SWCT_TMR_W = 24;

   // ----------------------------------------------------------------------
   // Wake sequencer states, one-hot
   // ----------------------------------------------------------------------
   typedef enum logic [5:0] {
      SWCT_RUN       = 6'h01,
      SWCT_SUSP      = 6'h02,
      SWCT_INT_START = 6'h04,
      SWCT_INT_TMO   = 6'h08,
      SWCT_EXT_STAB  = 6'h10,
      SWCT_EXT_DLY   = 6'h20
   } swct_state_t;

   // All state of the top module except the h_dly check counter
   typedef struct packed {
      swct_state_t state;
      logic [SWCT_CNT_W-1:0] cnt;
      logic ext_sel;
      logic [2:0] adj;
      logic dly_long;
      logic run;
      logic [1:0] mask;
      logic [1:0] stat;
      logic ext_active;
      logic wake_ext;
      logic int_clk;
      logic ext_osc;
      logic [7:0] rdata;
      logic wake_m;
      logic wake_s;
      logic stab_m;
      logic stab_s;
   } swct_regs_t;

   // All state of the wake-up timer
   typedef struct packed {
      logic [SWCT_TMR_W-1:0] cnt;
      logic expire;
   } swct_tmr_t;

endpackage : swct_pkg

// ### hw/swct_wake_timer.sv
// Periodic wake-up timer with power-of-two period adjust.
// Assumes enable and adjust come from registers on the same clock.
`include "swct_cfg.svh"
module swct_wake_timer #(
   parameter int BASE_CYC = `SWCT_WAKE_BASE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic [2:0] adj_i,
   output logic expire_o
);

   swct_pkg::swct_tmr_t s_q;
   swct_pkg::swct_tmr_t s_d;
   logic [swct_pkg::SWCT_TMR_W-1:0] limit;

   // ----------------------------------------------------------------------
   // Period counter
   // ----------------------------------------------------------------------
   // Period is base times two to the adjust code
   assign limit = (swct_pkg::SWCT_TMR_W'(BASE_CYC) << adj_i) - 24'h000001; // RL14

   // Count while enabled, clear when disabled
   always_comb begin
      s_d = s_q;
      s_d.expire = 1'b0;
      if (!en_i) begin
         s_d.cnt = '0; // RL9 RL12
      end else if (s_q.cnt >= limit) begin
         s_d.cnt = '0;
         s_d.expire = 1'b1; // RL11
      end else begin
         s_d.cnt = s_q.cnt + 24'h000001;
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign expire_o = s_q.expire;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_timer_gated_off: assert property ( // RL9
      @(posedge clk_i) disable iff (rst_i)
      !en_i |=> (s_q.cnt == '0) && !s_q.expire)
      else $error("wake timer ran while disabled");

   a_timer_full_period: assert property ( // RL11
      @(posedge clk_i) disable iff (rst_i)
      $rose(en_i) && (adj_i == 3'h0) && (BASE_CYC == 2)
      ##1 (en_i && adj_i == 3'h0) [*2] |-> s_q.expire)
      else $error("wake timer period wrong");

   a_expire_at_limit: assert property ( // RL14
      @(posedge clk_i) disable iff (rst_i)
      s_q.expire |-> (s_q.cnt == '0) && ($past(s_q.cnt) >= $past(limit)))
      else $error("wake timer expired early");

endmodule : swct_wake_timer

// ### verif/swct_top_tb_top.sv
// Self-checking bench of the suspend, wake and clock timer block.
// Assumes the design files and swct_cfg.svh on the include path; one 20 MHz clock.
`include "swct_cfg.svh"
module swct_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------------
   // Bench settings and signals
   // ----------------------------------------------------------------------
   localparam int LONG_CYC = 300; // Short stand-in for the 4 ms delay
   localparam int BASE_CYC = 2;
   localparam int RST_CYC = `SWCT_RESTART_CYC;
   localparam int TMO_CYC = `SWCT_INT_TMO_CYC;
   logic clk_i, rst_i, wr_i, rd_i, wake_event_i, ext_stable_i;
   logic [7:0] addr_i, wdata_i, rdata_o;
   logic cpu_run_o, suspend_o, int_clk_en_o, ext_osc_en_o, ext_clk_sel_o, irq_o;
   int error_cnt = 0;
   int n_checks = 0;
   int n, m, p;

   swct_top #(.LONG_DLY_CYC(LONG_CYC), .WAKE_BASE_CYC(BASE_CYC)) swct_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .wake_event_i(wake_event_i),
      .ext_stable_i(ext_stable_i), .cpu_run_o(cpu_run_o), .suspend_o(suspend_o),
      .int_clk_en_o(int_clk_en_o), .ext_osc_en_o(ext_osc_en_o),
      .ext_clk_sel_o(ext_clk_sel_o), .irq_o(irq_o));

   // Free-running system clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------------
   // Compare, bus and wait tasks
   // ----------------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask : chk8

   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      n_checks++;
      if (got < lo || got > hi) begin
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
         error_cnt++;
      end
   endtask : chk_rng

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr

   // Empty label reads without comparing, to clear sticky status
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      if (what != "") begin
         chk8(what, exp, rdata_o);
      end
   endtask : rd

   function automatic logic pick(input int sel);
      case (sel)
         0: pick = cpu_run_o;
         1: pick = int_clk_en_o;
         2: pick = ext_osc_en_o;
         default: pick = irq_o;
      endcase
   endfunction : pick

   // Bounded wait for an output level; running out ends the run
   task automatic wait_for(input int sel, input logic val, input int max, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk_i);
         #1;
         cnt++;
      end while (pick(sel) !== val && cnt < max);
      if (pick(sel) !== val) begin
         $display("CHECK FAILED wait on output %0d expected %b seen %b", sel, val, pick(sel));
         error_cnt++;
         close_out();
      end
   endtask : wait_for

   // External start: oscillator on, stall for stability, then the delay
   task automatic ext_seq(input int dly);
      int k;
      wait_for(2, 1'b1, 10, k);
      repeat (20) @(posedge clk_i);
      #1;
      chk8("halted while unstable", 8'h00, {7'h00, cpu_run_o});
      @(posedge clk_i);
      ext_stable_i <= 1'b1;
      wait_for(0, 1'b1, dly + 8, k);
      chk_rng("external delay", dly, dly + 4, k);
      chk8("external clocking", 8'h03, {6'h00, ext_osc_en_o, ext_clk_sel_o});
   endtask : ext_seq

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      wake_event_i = 1'b0;
      ext_stable_i = 1'b0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      // Reset state and register defaults
      chk8("reset outputs", 8'h28, {2'h0, cpu_run_o, suspend_o, int_clk_en_o,
                                    ext_osc_en_o, ext_clk_sel_o, irq_o});
      rd(`SWCT_ADDR_CLKCFG, 8'h00, "clkcfg reset");
      rd(`SWCT_ADDR_PSC, 8'h01, "psc reset");
      rd(`SWCT_ADDR_MASK, 8'h00, "mask reset");
      rd(8'h7f, 8'h00, "unmapped read");
      $display("test reset done");

      // Internal-clock wake, resume interrupt masked then unmasked
      wr(`SWCT_ADDR_PSC, 8'h09);
      chk8("suspend entry", 8'h01, {6'h00, cpu_run_o, suspend_o});
      rd(`SWCT_ADDR_PSC, 8'h09, "psc in suspend");
      @(posedge clk_i);
      wake_event_i <= 1'b1;
      wait_for(1, 1'b0, 10, n);
      wait_for(1, 1'b1, RST_CYC + 4, m);
      chk_rng("clock restart", 1, RST_CYC, n + m);
      wait_for(0, 1'b1, TMO_CYC + 4, n);
      chk_rng("internal timeout", TMO_CYC, TMO_CYC + 1, n);
      chk8("internal clocking", 8'h00, {6'h00, ext_osc_en_o, ext_clk_sel_o});
      @(posedge clk_i);
      wake_event_i <= 1'b0;
      #1;
      chk8("masked irq", 8'h00, {7'h00, irq_o});
      wr(`SWCT_ADDR_MASK, 8'h02);
      chk8("resume irq", 8'h01, {7'h00, irq_o});
      rd(`SWCT_ADDR_STAT, 8'h02, "resume status");
      chk8("irq after read", 8'h00, {7'h00, irq_o});
      wr(`SWCT_ADDR_MASK, 8'h00);
      $display("test internal wake done");

      // Wake refused while the run bit is clear, taken once it is set
      wr(`SWCT_ADDR_PSC, 8'h08);
      @(posedge clk_i);
      wake_event_i <= 1'b1;
      repeat (300) @(posedge clk_i);
      #1;
      chk8("no resume without run", 8'h00, {7'h00, cpu_run_o});
      wr(`SWCT_ADDR_PSC, 8'h01);
      wait_for(0, 1'b1, RST_CYC + TMO_CYC + 10, n);
      chk_rng("resume after run", RST_CYC + TMO_CYC - 4, RST_CYC + TMO_CYC, n);
      @(posedge clk_i);
      wake_event_i <= 1'b0;
      rd(`SWCT_ADDR_STAT, 8'h02, "resume status");
      $display("test run bit done");

      // Switch to external clock while running on the internal one
      wr(`SWCT_ADDR_CLKCFG, 8'h01);
      ext_seq(`SWCT_EXT_SHORT_CYC);
      rd(`SWCT_ADDR_STAT, 8'h02, "switch status");
      $display("test clock switch done");

      // External-clock wake with both delay selections
      for (int i = 0; i < 2; i++) begin
         wr(`SWCT_ADDR_CLKCFG, (i == 1) ? 8'h81 : 8'h01);
         wr(`SWCT_ADDR_PSC, 8'h09);
         @(posedge clk_i);
         ext_stable_i <= 1'b0;
         repeat (10) @(posedge clk_i);
         wake_event_i <= 1'b1;
         ext_seq((i == 1) ? LONG_CYC : `SWCT_EXT_SHORT_CYC);
         @(posedge clk_i);
         wake_event_i <= 1'b0;
         rd(`SWCT_ADDR_STAT, 8'h02, "external resume status");
      end
      $display("test external wake done");

      // Wake timer period for every adjust code, restarted from a cleared count
      for (int k = 0; k < 8; k++) begin
         p = BASE_CYC << k;
         wr(`SWCT_ADDR_MASK, 8'h00);
         wr(`SWCT_ADDR_CLKCFG, {1'b0, k[2:0], 4'h0});
         rd(`SWCT_ADDR_STAT, 8'h00, "");
         wr(`SWCT_ADDR_MASK, 8'h01);
         wait_for(3, 1'b1, p + 6, n);
         chk_rng("first period", p, p + 3, n);
         if (k >= 2) begin
            rd(`SWCT_ADDR_STAT, 8'h01, "timer status");
            wait_for(3, 1'b1, p + 2, m);
            chk_rng("repeat period", p, p, m + 2);
         end
      end
      wr(`SWCT_ADDR_MASK, 8'h00);
      rd(`SWCT_ADDR_STAT, 8'h00, "");
      repeat (600) @(posedge clk_i);
      rd(`SWCT_ADDR_STAT, 8'h00, "stopped timer");
      $display("test wake timer done");

      // Timer expiry wakes the part from suspend
      p = BASE_CYC << 7;
      wr(`SWCT_ADDR_MASK, 8'h01);
      wr(`SWCT_ADDR_PSC, 8'h09);
      chk8("timer suspend", 8'h01, {6'h00, cpu_run_o, suspend_o});
      wait_for(0, 1'b1, p + RST_CYC + TMO_CYC + 10, n);
      chk_rng("timer wake", p - 4 + TMO_CYC, p + RST_CYC + TMO_CYC + 8, n);
      wr(`SWCT_ADDR_MASK, 8'h00);
      $display("test timer wake done");

      // Reset in mid-run clears the adjust field
      wr(`SWCT_ADDR_CLKCFG, 8'h70);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk8("reset outputs again", 8'h28, {2'h0, cpu_run_o, suspend_o, int_clk_en_o,
                                          ext_osc_en_o, ext_clk_sel_o, irq_o});
      rd(`SWCT_ADDR_CLKCFG, 8'h00, "clkcfg after reset");
      $display("test second reset done");
      close_out();
   end
endmodule : swct_top_tb_top
